// [rtl/kwu_pkg.sv]
package kwu_pkg;

    // register map
    localparam logic [15:0] KWU_ENABLE_OFS = 16'h0f9f;
    localparam logic [15:0] KWU_STATUS_OFS = 16'h0fa0;

    // key_wake_enable fields
    localparam int KWU_EN_LSB = 4;
    localparam int KWU_EN_MSB = 7;
    localparam logic [3:0] KWU_EN_RST = 4'h0;

    // status register fields
    localparam int KWU_ST_STANDBY = 0;
    localparam int KWU_ST_WARMUP = 1;
    localparam int KWU_ST_RELM = 2;
    localparam int KWU_ST_PIN_LSB = 4;

    // idle and unmapped read value
    localparam logic [7:0] KWU_RDATA_IDLE = 8'h00;

    // release-method select of system_control_one
    localparam logic KWU_RELM_EDGE = 1'b0;
    localparam logic KWU_RELM_LEVEL = 1'b1;

    // warm-up timing
    localparam int KWU_CLK_PERIOD_NS = 10;
    localparam int KWU_WARMUP_NS = 2000;
    localparam int KWU_WARMUP_CYC = (KWU_WARMUP_NS + KWU_CLK_PERIOD_NS - 1) / KWU_CLK_PERIOD_NS;
    localparam logic [7:0] KWU_WARMUP_LOAD = 8'(KWU_WARMUP_CYC - 1);

    typedef enum logic [1:0] {
        KWU_RUN = 2'b00,
        KWU_STANDBY = 2'b01,
        KWU_WARMUP = 2'b10
    } kwu_state_t;

    typedef struct packed {
        logic [15:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } kwu_bus_req_t;

endpackage : kwu_pkg

// [rtl/kwu_key_wakeup.sv]
`timescale 1ns/10ps

module kwu_key_wakeup (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire kwu_pkg::kwu_bus_req_t bus_req,
    output logic [7:0] reg_rdata_r,
    input wire logic [3:0] key_wake_pin,
    input wire logic standby_exit_pin,
    input wire logic release_mode,
    input wire logic stop_request,
    output logic osc_stop_r,
    output logic warmup_r,
    output logic cpu_resume_r
);

    function automatic logic addr_hit(input logic [15:0] a, input logic [15:0] ofs);
        addr_hit = (a == ofs);
    endfunction : addr_hit

    kwu_pkg::kwu_state_t state_r;
    kwu_pkg::kwu_state_t state_nxt;
    logic [3:0] en_r;
    logic [3:0] en_nxt;
    logic [7:0] warm_cnt_r;
    logic [7:0] warm_cnt_nxt;
    logic wake_meta_r;
    logic wake_sync_r;
    logic [7:0] rdata_nxt;

    wire wr_enable = bus_req.wr && addr_hit(bus_req.addr, kwu_pkg::KWU_ENABLE_OFS);
    wire rd_status = bus_req.rd && addr_hit(bus_req.addr, kwu_pkg::KWU_STATUS_OFS);
    wire level_mode = (release_mode == kwu_pkg::KWU_RELM_LEVEL);
    wire in_standby = (state_r == kwu_pkg::KWU_STANDBY);
    wire warm_done = (state_r == kwu_pkg::KWU_WARMUP) && (warm_cnt_r == 8'h00);

    // per-pin release terms, purely combinational since the clock is
    // stopped in standby
    wire [3:0] key_low;
    wire [3:0] key_hit;
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_key
            // enabled pin pulled low, seen in either release mode
            assign key_low[gi] = en_r[gi] & ~key_wake_pin[gi];
            // key pins cannot release standby in edge mode; they must not be used there
            assign key_hit[gi] = key_low[gi] & level_mode;
        end
    endgenerate

    // exit pin always releases; low at entry so any high in standby is
    // also the rising edge that edge mode asks for
    wire wake_now = standby_exit_pin | (|key_hit);

    // entry check is mode-blind: a low enabled key skips standby even in edge mode
    wire entry_block = standby_exit_pin | (|key_low);

    // status readback shows live block state
    wire [7:0] status_word = {key_wake_pin, 1'b0, release_mode,
                              (state_r == kwu_pkg::KWU_WARMUP), in_standby};

    // enables only ever change through a write or a reset
    assign en_nxt = wr_enable ? bus_req.wdata[kwu_pkg::KWU_EN_MSB:kwu_pkg::KWU_EN_LSB]
                              : en_r;

    // write-only enables: that address reads as idle value
    assign rdata_nxt = rd_status ? status_word : kwu_pkg::KWU_RDATA_IDLE;

    always_comb begin
        state_nxt = state_r;
        warm_cnt_nxt = warm_cnt_r;
        case (state_r)
            kwu_pkg::KWU_RUN: begin
                if (stop_request) begin
                    if (entry_block) begin
                        state_nxt = kwu_pkg::KWU_WARMUP;
                        warm_cnt_nxt = kwu_pkg::KWU_WARMUP_LOAD;
                    end else begin
                        state_nxt = kwu_pkg::KWU_STANDBY;
                    end
                end
            end
            kwu_pkg::KWU_STANDBY: begin
                if (wake_sync_r) begin
                    state_nxt = kwu_pkg::KWU_WARMUP;
                    warm_cnt_nxt = kwu_pkg::KWU_WARMUP_LOAD;
                end
            end
            kwu_pkg::KWU_WARMUP: begin
                if (warm_done) begin
                    state_nxt = kwu_pkg::KWU_RUN;
                end else begin
                    warm_cnt_nxt = warm_cnt_r - 8'h01;
                end
            end
            default: begin
                state_nxt = kwu_pkg::KWU_RUN;
                warm_cnt_nxt = 8'h00;
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            en_r <= kwu_pkg::KWU_EN_RST;
            reg_rdata_r <= kwu_pkg::KWU_RDATA_IDLE;
        end else begin
            en_r <= en_nxt;
            reg_rdata_r <= rdata_nxt;
        end
    end

    // two-flop resync of the asynchronous wake level; cleared outside
    // standby so a level seen before entry cannot fake a release
    always_ff @(posedge ref_clk) begin
        if (!rst_n || !in_standby) begin
            wake_meta_r <= 1'b0;
            wake_sync_r <= 1'b0;
        end else begin
            wake_meta_r <= wake_now;
            wake_sync_r <= wake_meta_r;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            state_r <= kwu_pkg::KWU_RUN;
            warm_cnt_r <= 8'h00;
            osc_stop_r <= 1'b0;
            warmup_r <= 1'b0;
            cpu_resume_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            warm_cnt_r <= warm_cnt_nxt;
            osc_stop_r <= (state_nxt == kwu_pkg::KWU_STANDBY);
            warmup_r <= (state_nxt == kwu_pkg::KWU_WARMUP);
            cpu_resume_r <= warm_done;
        end
    end

    a_enable_reset_zero: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        $past(!rst_n) && !$past(wr_enable) |-> en_r == 4'h0)
        else $error("enables not zero after reset");

    a_enable_write_take: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        wr_enable |=> en_r == $past(bus_req.wdata[7:4]))
        else $error("enable write not taken from bits 7..4");

    a_enable_read_hidden: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        bus_req.rd && addr_hit(bus_req.addr, kwu_pkg::KWU_ENABLE_OFS)
        |=> reg_rdata_r == 8'h00)
        else $error("enable register readable");

    a_entry_blocked_wake: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        state_r == kwu_pkg::KWU_RUN && stop_request && entry_block
        |=> state_r == kwu_pkg::KWU_WARMUP && !osc_stop_r && warmup_r)
        else $error("standby entered despite active wake source");

    a_exit_pin_always: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        state_r == kwu_pkg::KWU_RUN && stop_request && standby_exit_pin
        |=> !osc_stop_r)
        else $error("exit pin did not block standby");

    a_entry_standby_ok: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        state_r == kwu_pkg::KWU_RUN && stop_request && !entry_block
        |=> osc_stop_r && state_r == kwu_pkg::KWU_STANDBY)
        else $error("standby not entered");

    a_key_release_lat: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        (in_standby && wake_now)[*3] |=> state_r == kwu_pkg::KWU_WARMUP && !osc_stop_r)
        else $error("held wake level did not release standby in three cycles");

    a_standby_holds_quiet: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        in_standby && !wake_sync_r |=> in_standby && osc_stop_r)
        else $error("standby left without synchronised wake");

    a_warmup_resume: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        warm_done |=> cpu_resume_r && state_r == kwu_pkg::KWU_RUN
        ##1 !cpu_resume_r)
        else $error("resume pulse wrong at warm-up end");

    a_edge_mode_keys: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        !level_mode |-> key_hit == 4'h0)
        else $error("key pin acted in edge release mode");

    a_edge_key_ignored: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        !level_mode && !standby_exit_pin |-> !wake_now)
        else $error("key pin woke the block in edge release mode");

    a_enable_held_idle: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        !wr_enable |=> en_r == $past(en_r))
        else $error("enables changed without a write");

    a_disabled_key_quiet: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        !standby_exit_pin && key_low == 4'h0 |-> !wake_now)
        else $error("disabled or high key pin raised a wake");

    a_read_idle_zero: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        !rd_status |=> reg_rdata_r == kwu_pkg::KWU_RDATA_IDLE)
        else $error("read data not idle outside a status read");

    a_status_read_data: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        rd_status |=> reg_rdata_r == $past(status_word))
        else $error("status read data wrong");

    a_osc_tracks_state: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        osc_stop_r == in_standby)
        else $error("oscillator stop flag out of step with standby");

    a_standby_after_stop: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        !in_standby ##1 in_standby |-> $past(stop_request))
        else $error("standby entered without a stop request");

    a_standby_no_resume: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        in_standby |-> !warmup_r && !cpu_resume_r)
        else $error("warm-up or resume active in standby");

    a_level_key_wakes: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        level_mode && key_low != 4'h0 |-> wake_now)
        else $error("enabled low key pin gave no wake in level mode");

    a_exit_pin_wakes: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        standby_exit_pin |-> wake_now)
        else $error("exit pin high gave no wake");

    a_entry_key_low: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        state_r == kwu_pkg::KWU_RUN && stop_request && key_low != 4'h0
        |=> !osc_stop_r && warmup_r)
        else $error("low enabled key pin did not skip standby");

    a_warmup_entry_src: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        !warmup_r ##1 warmup_r |-> $past(stop_request) || $past(wake_sync_r))
        else $error("warm-up started without a cause");

    a_warmup_tracks_state: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        warmup_r == (state_r == kwu_pkg::KWU_WARMUP))
        else $error("warm-up flag out of step with state");

    a_warm_count_load: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        state_r != kwu_pkg::KWU_WARMUP ##1 state_r == kwu_pkg::KWU_WARMUP
        |-> warm_cnt_r == kwu_pkg::KWU_WARMUP_LOAD)
        else $error("warm-up count not loaded on entry");

    a_warm_count_step: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        state_r == kwu_pkg::KWU_WARMUP && warm_cnt_r != 8'h00
        |=> state_r == kwu_pkg::KWU_WARMUP && warm_cnt_r == $past(warm_cnt_r) - 8'h01)
        else $error("warm-up count did not step down");

    a_resume_after_done: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        cpu_resume_r |-> $past(warm_done))
        else $error("resume pulse without end of warm-up");

    a_resume_one_cycle: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        cpu_resume_r |=> !cpu_resume_r)
        else $error("resume pulse longer than one cycle");

    a_sync_clear_idle: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        !in_standby |=> !wake_meta_r && !wake_sync_r)
        else $error("wake synchroniser not cleared outside standby");

    a_sync_first_stage: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        in_standby |=> wake_meta_r == $past(wake_now))
        else $error("first sync stage missed the wake level");

    a_sync_second_stage: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        in_standby |=> wake_sync_r == $past(wake_meta_r))
        else $error("second sync stage missed the first");

endmodule : kwu_key_wakeup

// [tb/kwu_key_model.sv]
`timescale 1ns/10ps
module kwu_key_model (
    input wire logic [3:0] press,
    input wire logic exit_req,
    output logic [3:0] key_wake_pin,
    output logic standby_exit_pin
);
    // switches pull up when open, so a released key reads high
    assign key_wake_pin = ~press;
    // kept low unless the bench asks for a release
    assign standby_exit_pin = exit_req;
endmodule : kwu_key_model

// [tb/key_wakeup_standby_release_tb.sv]
`timescale 1ns/10ps
module key_wakeup_standby_release_tb;
    logic ref_clk = 0, rst_n = 0, release_mode = 1, stop_request = 0, exit_req = 0;
    logic [3:0] press = 0, key_wake_pin;
    logic standby_exit_pin, osc_stop_r, warmup_r, cpu_resume_r;
    logic [7:0] reg_rdata_r;
    kwu_pkg::kwu_bus_req_t bus_req = '0;
    int bad_count = 0, cmp_count = 0, seed = 22479, en = 0, n, i;
    localparam logic [15:0] EN_A = kwu_pkg::KWU_ENABLE_OFS;
    localparam logic [15:0] ST_A = kwu_pkg::KWU_STATUS_OFS;
    initial forever #5 ref_clk = ~ref_clk;
    kwu_key_model km (.press(press), .exit_req(exit_req), .key_wake_pin(key_wake_pin),
        .standby_exit_pin(standby_exit_pin));
    kwu_key_wakeup DUT (.ref_clk(ref_clk), .rst_n(rst_n), .bus_req(bus_req),
        .reg_rdata_r(reg_rdata_r), .key_wake_pin(key_wake_pin),
        .standby_exit_pin(standby_exit_pin), .release_mode(release_mode),
        .stop_request(stop_request), .osc_stop_r(osc_stop_r), .warmup_r(warmup_r),
        .cpu_resume_r(cpu_resume_r));
    task chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task stop_test;
        $display("bad_count=%0d cmp_count=%0d", bad_count, cmp_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : stop_test
    task wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        bus_req <= '{a, d, 1'b1, 1'b0};
        @(posedge ref_clk);
        bus_req <= '0;
    endtask : wr
    task rd(input logic [15:0] a, input logic [7:0] e);
        @(posedge ref_clk);
        bus_req <= '{a, 8'h00, 1'b0, 1'b1};
        @(posedge ref_clk);
        bus_req <= '0;
        #1 chk(reg_rdata_r, e);
    endtask : rd
    // warm-up is timed from its first cycle, then pins are let go
    task warm;
        n = 0;
        while (warmup_r === 1'b1 && n < 300) begin
            @(posedge ref_clk);
            #1 n++;
        end
        chk(8'(n), 8'(kwu_pkg::KWU_WARMUP_CYC));
        chk({7'h0, cpu_resume_r}, 8'h01);
        @(posedge ref_clk);
        #1 chk({7'h0, cpu_resume_r}, 8'h00);
        @(posedge ref_clk);
        press <= '0;
        exit_req <= 1'b0;
        @(posedge ref_clk);
    endtask : warm
    task enter(input logic sk);
        @(posedge ref_clk);
        stop_request <= 1'b1;
        @(posedge ref_clk);
        stop_request <= 1'b0;
        #1 chk({6'h0, osc_stop_r, warmup_r}, sk ? 8'h01 : 8'h02);
        if (sk) warm();
    endtask : enter
    task wk(input logic [3:0] pr, input logic ex);
        logic w;
        w = ex | (release_mode & |(4'(en) & pr));
        @(posedge ref_clk);
        press <= pr;
        exit_req <= ex;
        n = 0;
        while (osc_stop_r === 1'b1 && n < 8) begin
            @(posedge ref_clk);
            #1 n++;
        end
        chk({7'h0, osc_stop_r}, {7'h0, !w});
        if (w) begin
            chk({7'h0, n <= 4}, 8'h01);
            warm();
        end
    endtask : wk
    initial begin
        repeat (16) @(posedge ref_clk);
        rst_n <= 1'b1;
        rd(EN_A, 8'h00);
        rd(16'h1234, 8'h00);
        enter(1'b0);
        wk(4'hf, 1'b0);
        wk(4'h0, 1'b1);
        for (i = 0; i < 4; i++) begin
            en = 1 << i;
            wr(EN_A, {4'(en), 4'($random(seed))});
            rd(EN_A, 8'h00);
            rd(ST_A, 8'hf4);
            enter(1'b0);
            wk(4'(~en) & 4'($random(seed)), 1'b0);
            wk(4'(en), 1'b0);
            press <= 4'(en);
            enter(1'b1);
        end
        // reset in mid-run must clear the enable left from the loop
        rst_n <= 1'b0;
        repeat (2) @(posedge ref_clk);
        rst_n <= 1'b1;
        en = 0;
        enter(1'b0);
        wk(4'hf, 1'b0);
        wk(4'h0, 1'b1);
        // edge release: keys disabled, enabled and held high, or enabled and low at entry
        release_mode <= 1'b0;
        wr(EN_A, 8'h00);
        en = 0;
        enter(1'b0);
        wk(4'hf, 1'b0);
        wk(4'h0, 1'b1);
        wr(EN_A, 8'hf0);
        en = 15;
        enter(1'b0);
        wk(4'h0, 1'b1);
        press <= 4'h1;
        enter(1'b1);
        exit_req <= 1'b1;
        enter(1'b1);
        stop_test();
    end
    initial begin
        repeat (20000) @(posedge ref_clk);
        bad_count++;
        stop_test();
    end
endmodule : key_wakeup_standby_release_tb
